//--- src/ccr_pkg.sv
// shared constants and carrier types for the core register set
package ccr_pkg;
   // special register addresses
   localparam logic [7:0] CCR_ADDR_ACC = 8'he0;
   localparam logic [7:0] CCR_ADDR_B = 8'hf0;
   localparam logic [7:0] CCR_ADDR_PSW = 8'hd0;
   localparam logic [7:0] CCR_ADDR_SP = 8'h81;
   localparam logic [7:0] CCR_ADDR_DPL = 8'h82;
   localparam logic [7:0] CCR_ADDR_DPH = 8'h83;
   localparam logic [7:0] CCR_ADDR_POINTER_ONE_LOW = 8'h84;
   localparam logic [7:0] CCR_ADDR_POINTER_ONE_HIGH = 8'h85;
   localparam logic [7:0] CCR_ADDR_CFG = 8'h86;
   localparam logic [7:0] CCR_ADDR_EXTENSION_BYTE_REG = 8'hf1;
   localparam logic [7:0] CCR_ADDR_XPG = 8'hf7;
   // reset values
   localparam logic [7:0] CCR_SP_RST = 8'h07;
   localparam logic [7:0] CCR_ZERO8 = 8'h00;
   localparam logic [7:0] CCR_ONE8 = 8'h01;
   // status word bit positions
   localparam int CCR_PSW_CY = 7;
   localparam int CCR_PSW_AC = 6;
   localparam int CCR_PSW_F0 = 5;
   localparam int CCR_PSW_RSH = 4;
   localparam int CCR_PSW_RSL = 3;
   localparam int CCR_PSW_OV = 2;
   localparam int CCR_PSW_F1 = 1;
   localparam int CCR_PSW_P = 0;
   // config bit positions and writable mask
   localparam int CCR_CFG_DPS = 0;
   localparam int CCR_CFG_MUL = 2;
   localparam int CCR_CFG_DIV = 3;
   localparam int CCR_CFG_BKS = 6;
   localparam logic [7:0] CCR_CFG_MASK = 8'h4d;
   localparam logic [7:0] CCR_PSW_MASK = 8'hfe;
   localparam logic [7:0] CCR_XPG_MASK = 8'h3f;
   localparam logic [7:0] CCR_UPPER_BIT = 8'h80;

   // operations issued by the fetch and decode logic
   typedef enum logic [2:0] {
      CCR_OP_NONE,
      CCR_OP_PUSH,
      CCR_OP_POP,
      CCR_OP_MUL,
      CCR_OP_DIV,
      CCR_OP_FLAGS
   } ccr_op_t;

   // request from decode
   typedef struct packed {
      ccr_op_t op;
      logic cy;
      logic ac;
      logic ov;
   } ccr_req_t;

   // memory routing request
   typedef struct packed {
      logic valid;
      logic indirect;
      logic [7:0] addr;
   } ccr_mreq_t;

   // routed memory target
   typedef struct packed {
      logic to_sfr;
      logic to_upper;
      logic to_lower;
      logic [7:0] addr;
   } ccr_route_t;
endpackage

//--- src/ccr_core_regs.sv
// core register set: accumulator, operands, flags, stack and pointers
// ---------------------------------------------------------------
// ---------------------------------------------------------------
`timescale 1ns/1ps
module ccr_core_regs
   import ccr_pkg::*;
(
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire ccr_req_t req_in,
   input wire logic sfr_wr_in,
   input wire logic [7:0] sfr_addr_in,
   input wire logic [7:0] sfr_wdata_in,
   input wire ccr_mreq_t mreq_in,
   input wire logic xmov_in,
   input wire logic xmov_ptr_in,
   input wire logic [7:0] xmov_ri_in,
   output logic [7:0] sfr_rdata_out,
   output logic [7:0] stack_addr_out,
   output logic [7:0] acc_out,
   output logic [7:0] status_out,
   output logic [15:0] active_ptr_out,
   output logic [7:0] reg_group_base_out,
   output logic sfr_bank_out,
   output ccr_route_t route_out,
   output logic xram_en_out,
   output logic [7:0] xram_addr_out,
   output logic div_zero_out
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] acc;
      logic [7:0] b;
      logic [7:0] ext;
      logic [7:0] sp;
      logic [7:0] program_status_word;
      logic [7:0] cfg;
      logic [7:0] xpg;
      logic [15:0] dptr0;
      logic [15:0] addr_pointer_one;
      logic [15:0] aptr;
      logic [7:0] rdata;
      logic [7:0] stack_addr;
      ccr_route_t route;
      logic xen;
      logic [7:0] xaddr;
      logic dz;
   } ccr_state_t;

   ccr_state_t st;
   ccr_state_t next_st;
   logic [15:0] prod16;
   logic [23:0] prod24;
   logic [15:0] dividend;
   logic [15:0] quot;
   logic [7:0] rem;
   logic [15:0] rem16;

   // arithmetic for multiply and divide
   always_comb begin
      prod16 = 16'(st.acc * st.b);
      prod24 = 24'({st.ext, st.acc} * st.b);
      dividend = st.cfg[CCR_CFG_DIV] ? {st.ext, st.acc} : {CCR_ZERO8, st.acc};
      if (st.b == CCR_ZERO8) begin
         quot = 16'hffff;
         rem16 = dividend;
      end else begin
         quot = dividend / {CCR_ZERO8, st.b};
         rem16 = dividend % {CCR_ZERO8, st.b};
      end
      rem = rem16[7:0];
   end

   // next state
   always_comb begin
      next_st = st;
      // direct special register writes, bank independent core regs
      if (sfr_wr_in) begin
         case (sfr_addr_in)
            CCR_ADDR_ACC: begin
               next_st.acc = sfr_wdata_in;
            end
            CCR_ADDR_B: begin
               next_st.b = sfr_wdata_in;
            end
            CCR_ADDR_EXTENSION_BYTE_REG: begin
               next_st.ext = sfr_wdata_in;
            end
            CCR_ADDR_SP: begin
               next_st.sp = sfr_wdata_in;
            end
            CCR_ADDR_PSW: begin
               next_st.program_status_word = sfr_wdata_in & CCR_PSW_MASK;
            end
            CCR_ADDR_CFG: begin
               next_st.cfg = sfr_wdata_in & CCR_CFG_MASK;
            end
            CCR_ADDR_XPG: begin
               next_st.xpg = sfr_wdata_in & CCR_XPG_MASK;
            end
            CCR_ADDR_DPL: begin
               if (st.cfg[CCR_CFG_DPS]) begin
                  next_st.addr_pointer_one[7:0] = sfr_wdata_in;
               end else begin
                  next_st.dptr0[7:0] = sfr_wdata_in;
               end
            end
            CCR_ADDR_DPH: begin
               if (st.cfg[CCR_CFG_DPS]) begin
                  next_st.addr_pointer_one[15:8] = sfr_wdata_in;
               end else begin
                  next_st.dptr0[15:8] = sfr_wdata_in;
               end
            end
            CCR_ADDR_POINTER_ONE_LOW: begin
               next_st.addr_pointer_one[7:0] = sfr_wdata_in;
            end
            CCR_ADDR_POINTER_ONE_HIGH: begin
               next_st.addr_pointer_one[15:8] = sfr_wdata_in;
            end
            default: begin
            end
         endcase
      end
      // decode operations, issued after any direct write
      next_st.dz = 1'b0;
      case (req_in.op)
         CCR_OP_PUSH: begin
            next_st.sp = 8'(st.sp + CCR_ONE8);
            next_st.stack_addr = 8'(st.sp + CCR_ONE8);
         end
         CCR_OP_POP: begin
            next_st.stack_addr = st.sp;
            next_st.sp = 8'(st.sp - CCR_ONE8);
         end
         CCR_OP_MUL: begin
            if (st.cfg[CCR_CFG_MUL]) begin
               next_st.acc = prod24[7:0];
               next_st.b = prod24[15:8];
               next_st.ext = prod24[23:16];
               next_st.program_status_word[CCR_PSW_OV] = (prod24[23:8] != 16'h0000);
            end else begin
               next_st.acc = prod16[7:0];
               next_st.b = prod16[15:8];
               next_st.program_status_word[CCR_PSW_OV] = (prod16[15:8] != CCR_ZERO8);
            end
            next_st.program_status_word[CCR_PSW_CY] = 1'b0;
         end
         CCR_OP_DIV: begin
            next_st.acc = quot[7:0];
            next_st.b = rem;
            if (st.cfg[CCR_CFG_DIV]) begin
               next_st.ext = quot[15:8];
            end
            next_st.dz = (st.b == CCR_ZERO8);
            next_st.program_status_word[CCR_PSW_OV] = (st.b == CCR_ZERO8);
            next_st.program_status_word[CCR_PSW_CY] = 1'b0;
         end
         CCR_OP_FLAGS: begin
            next_st.program_status_word[CCR_PSW_CY] = req_in.cy;
            next_st.program_status_word[CCR_PSW_AC] = req_in.ac;
            next_st.program_status_word[CCR_PSW_OV] = req_in.ov;
         end
         default: begin
         end
      endcase
      // parity follows the final accumulator value, no feedback path
      next_st.program_status_word[CCR_PSW_P] = ^next_st.acc;
      // read mux, follows the state before this cycle's writes
      case (sfr_addr_in)
         CCR_ADDR_ACC: next_st.rdata = st.acc;
         CCR_ADDR_B: next_st.rdata = st.b;
         CCR_ADDR_EXTENSION_BYTE_REG: next_st.rdata = st.ext;
         CCR_ADDR_SP: next_st.rdata = st.sp;
         CCR_ADDR_PSW: next_st.rdata = st.program_status_word;
         CCR_ADDR_CFG: next_st.rdata = st.cfg;
         CCR_ADDR_XPG: next_st.rdata = st.xpg;
         CCR_ADDR_DPL: next_st.rdata =
            st.cfg[CCR_CFG_DPS] ? st.addr_pointer_one[7:0] : st.dptr0[7:0];
         CCR_ADDR_DPH: next_st.rdata =
            st.cfg[CCR_CFG_DPS] ? st.addr_pointer_one[15:8] : st.dptr0[15:8];
         CCR_ADDR_POINTER_ONE_LOW: next_st.rdata = st.addr_pointer_one[7:0];
         CCR_ADDR_POINTER_ONE_HIGH: next_st.rdata = st.addr_pointer_one[15:8];
         default: next_st.rdata = CCR_ZERO8;
      endcase
      // internal memory routing
      next_st.route.addr = mreq_in.addr;
      next_st.route.to_lower = mreq_in.valid &
         ((mreq_in.addr & CCR_UPPER_BIT) == CCR_ZERO8);
      next_st.route.to_upper = mreq_in.valid & mreq_in.indirect &
         ((mreq_in.addr & CCR_UPPER_BIT) != CCR_ZERO8);
      next_st.route.to_sfr = mreq_in.valid & ~mreq_in.indirect &
         ((mreq_in.addr & CCR_UPPER_BIT) != CCR_ZERO8);
      // external ram, 256 bytes, low byte of pointer or ri
      next_st.xen = xmov_in;
      if (xmov_ptr_in) begin
         next_st.xaddr = st.cfg[CCR_CFG_DPS] ? st.addr_pointer_one[7:0] : st.dptr0[7:0];
      end else begin
         next_st.xaddr = xmov_ri_in;
      end
      // active pointer view, registered so the output comes from a flop
      next_st.aptr = next_st.cfg[CCR_CFG_DPS] ?
         next_st.addr_pointer_one : next_st.dptr0;
   end

   // state register, all fields clear on reset except sp, which loads 07
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st <= '0;
         st.sp <= CCR_SP_RST;
         st.cfg <= CCR_ZERO8;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   always_comb begin
      sfr_rdata_out = st.rdata;
      stack_addr_out = st.stack_addr;
      acc_out = st.acc;
      status_out = st.program_status_word;
      active_ptr_out = st.aptr;
      reg_group_base_out = {3'h0, st.program_status_word[CCR_PSW_RSH:CCR_PSW_RSL], 3'h0};
      sfr_bank_out = st.cfg[CCR_CFG_BKS];
      route_out = st.route;
      xram_en_out = st.xen;
      xram_addr_out = st.xaddr;
      div_zero_out = st.dz;
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence push_seq;
      req_in.op == CCR_OP_PUSH && !(sfr_wr_in && sfr_addr_in == CCR_ADDR_SP);
   endsequence

   push_inc_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      push_seq |=> st.sp == 8'($past(st.sp) + 1) && stack_addr_out == st.sp)
      else $error("push did not pre-increment");
   pop_dec_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      req_in.op == CCR_OP_POP && !sfr_wr_in
      |=> stack_addr_out == $past(st.sp) && st.sp == 8'(stack_addr_out - 1))
      else $error("pop did not post-decrement");
   parity_flag_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      status_out[0] == ^acc_out)
      else $error("parity flag wrong");
   group_base_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      reg_group_base_out == 8'(status_out[4:3] * 8))
      else $error("register group base wrong");
   narrow_mul_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      req_in.op == CCR_OP_MUL && !st.cfg[CCR_CFG_MUL] && !sfr_wr_in
      |=> {st.b, acc_out} == 16'($past(st.acc) * $past(st.b)))
      else $error("narrow multiply wrong");
   wide_mul_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      req_in.op == CCR_OP_MUL && st.cfg[CCR_CFG_MUL] && !sfr_wr_in
      |=> {st.ext, st.b, acc_out} ==
      24'({$past(st.ext), $past(st.acc)} * $past(st.b)))
      else $error("wide multiply wrong");
   narrow_div_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      req_in.op == CCR_OP_DIV && !st.cfg[CCR_CFG_DIV] && st.b != 0 && !sfr_wr_in
      |=> acc_out == $past(st.acc) / $past(st.b))
      else $error("narrow divide wrong");
   route_split_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      mreq_in.valid && mreq_in.addr[7]
      |=> route_out.to_upper == $past(mreq_in.indirect)
      && route_out.to_sfr != route_out.to_upper)
      else $error("upper space routing wrong");

   // wide divide with a nonzero divisor
   sequence wide_div_seq;
      req_in.op == CCR_OP_DIV && st.cfg[CCR_CFG_DIV] &&
      st.b != CCR_ZERO8 && !sfr_wr_in;
   endsequence

   // divide by a zero divisor
   sequence zero_div_seq;
      req_in.op == CCR_OP_DIV && st.b == CCR_ZERO8 && !sfr_wr_in;
   endsequence

   // flag load from decode with no competing write
   sequence flag_load_seq;
      req_in.op == CCR_OP_FLAGS && !sfr_wr_in;
   endsequence

   wide_div_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      wide_div_seq |=> {st.ext, acc_out} ==
      16'({$past(st.ext), $past(st.acc)} / {CCR_ZERO8, $past(st.b)}))
      else $error("wide divide quotient wrong");
   div_zero_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      zero_div_seq |=> div_zero_out && status_out[CCR_PSW_OV])
      else $error("divide by zero not flagged");
   flag_load_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      flag_load_seq |=> status_out[CCR_PSW_CY] == $past(req_in.cy)
      && status_out[CCR_PSW_AC] == $past(req_in.ac)
      && status_out[CCR_PSW_OV] == $past(req_in.ov))
      else $error("flag load wrong");
   lower_route_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      mreq_in.valid && !mreq_in.addr[7]
      |=> route_out.to_lower && !route_out.to_upper && !route_out.to_sfr)
      else $error("lower space routing wrong");
   xram_ri_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      xmov_in && !xmov_ptr_in
      |=> xram_en_out && xram_addr_out == $past(xmov_ri_in))
      else $error("external move address wrong");
   ptr_select_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      active_ptr_out == (st.cfg[CCR_CFG_DPS] ? st.addr_pointer_one : st.dptr0))
      else $error("active pointer view wrong");
   cfg_mask_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      (st.cfg & ~CCR_CFG_MASK) == CCR_ZERO8)
      else $error("unused config bits set");
endmodule

//--- test/tb_top.sv
// self-checking bench for the core register set
`timescale 1ns/1ps
module tb_top;
   import ccr_pkg::*;
   // ---------------------------------------------------------------
   // signals, notes and design
   // ---------------------------------------------------------------
   typedef struct {int k; logic [15:0] e; int due;} ccr_note_t;
   logic clk_in = 1'b0, nrst_in = 1'b0, sfr_wr_in = 1'b0;
   logic xmov_in = 1'b0, xmov_ptr_in = 1'b0, bank, xen, dz;
   ccr_req_t req_in = '0;
   ccr_mreq_t mreq_in = '0;
   ccr_route_t rt;
   logic [7:0] sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, xmov_ri_in = 8'h00;
   logic [7:0] rdata, stk, acc, st, grp, xad, a, b, e, rm;
   logic [15:0] ptr, wd, q16;
   logic [23:0] res;
   logic [31:0] r = 32'h700de5e6;
   int mismatches = 0, checks_done = 0, cyc = 0;
   ccr_note_t q[$], n;
   string nm[10] = '{"rdata", "acc", "status", "stack", "pointer", "group",
                     "bank", "route", "xram", "divzero"};
   ccr_core_regs dut (.clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in),
      .sfr_wr_in(sfr_wr_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wdata_in(sfr_wdata_in), .mreq_in(mreq_in), .xmov_in(xmov_in),
      .xmov_ptr_in(xmov_ptr_in), .xmov_ri_in(xmov_ri_in),
      .sfr_rdata_out(rdata), .stack_addr_out(stk), .acc_out(acc),
      .status_out(st), .active_ptr_out(ptr), .reg_group_base_out(grp),
      .sfr_bank_out(bank), .route_out(rt), .xram_en_out(xen),
      .xram_addr_out(xad), .div_zero_out(dz));
   // 4 ns clock
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [15:0] seen(int k);
      case (k)
         0: return {8'h00, rdata};
         1: return {8'h00, acc};
         2: return {8'h00, st};
         3: return {8'h00, stk};
         4: return ptr;
         5: return {8'h00, grp};
         6: return {15'h0000, bank};
         7: return {5'h00, rt};
         8: return {7'h00, xen, xad};
         default: return {15'h0000, dz};
      endcase
   endfunction
   task automatic cmp(string s, logic [15:0] ex_v, logic [15:0] v);
      checks_done++;
      if (v !== ex_v) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", s, ex_v, v);
      end
   endtask
   // one clock step; strobes fall back to idle unless redriven
   // each strobe is driven exactly once per edge
   task automatic tick(logic w = 1'b0, logic x = 1'b0, logic m = 1'b0,
                       ccr_op_t o = CCR_OP_NONE);
      @(posedge clk_in);
      cyc++;
      req_in.op <= o;
      sfr_wr_in <= w;
      xmov_in <= x;
      mreq_in.valid <= m;
   endtask
   // note a result due one cycle after this request
   task automatic ex(int k, logic [15:0] v);
      q.push_back('{k, v, cyc + 1});
   endtask
   task automatic wr(logic [7:0] ad, logic [7:0] d);
      tick(1'b1);
      sfr_addr_in <= ad;
      sfr_wdata_in <= d;
   endtask
   task automatic rd(logic [7:0] ad, logic [7:0] v);
      tick();
      sfr_addr_in <= ad;
      ex(0, {8'h00, v});
   endtask
   task automatic op(ccr_op_t o, logic c, logic h, logic v);
      tick(1'b0, 1'b0, 1'b0, o);
      req_in.cy <= c;
      req_in.ac <= h;
      req_in.ov <= v;
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // result watcher takes due notes off the queue
   always @(negedge clk_in) begin
      while (q.size() > 0 && q[0].due <= cyc) begin
         n = q.pop_front();
         cmp(nm[n.k], n.e, seen(n.k));
      end
   end
   // watchdog
   initial begin
      #20000;
      mismatches++;
      test_done;
   end
   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      rd(CCR_ADDR_SP, 8'h07);
      rd(CCR_ADDR_PSW, 8'h00);
      rd(CCR_ADDR_CFG, 8'h00);
      op(CCR_OP_PUSH, 1'b0, 1'b0, 1'b0);
      ex(3, 16'h0008);
      op(CCR_OP_PUSH, 1'b0, 1'b0, 1'b0);
      ex(3, 16'h0009);
      op(CCR_OP_POP, 1'b0, 1'b0, 1'b0);
      ex(3, 16'h0009);
      rd(CCR_ADDR_SP, 8'h08);
      wr(CCR_ADDR_SP, 8'hff);
      op(CCR_OP_PUSH, 1'b0, 1'b0, 1'b0);
      ex(3, 16'h0000);
      $display("test stack done");
      r = lfsr(r);
      wr(CCR_ADDR_DPL, r[7:0]);
      wr(CCR_ADDR_DPH, r[15:8]);
      wr(CCR_ADDR_POINTER_ONE_LOW, r[23:16]);
      wr(CCR_ADDR_POINTER_ONE_HIGH, r[31:24]);
      ex(4, r[15:0]);
      wr(CCR_ADDR_CFG, 8'hff);
      ex(4, r[31:16]);
      ex(6, 16'h0001);
      rd(CCR_ADDR_CFG, 8'h4d);
      rd(CCR_ADDR_DPL, r[23:16]);
      tick(1'b0, 1'b1);
      xmov_ptr_in <= 1'b1;
      ex(8, {7'h00, 1'b1, r[23:16]});
      wr(CCR_ADDR_XPG, 8'hff);
      rd(CCR_ADDR_XPG, 8'h3f);
      wr(CCR_ADDR_XPG, 8'h00);
      tick(1'b0, 1'b1);
      xmov_ptr_in <= 1'b0;
      xmov_ri_in <= r[7:0];
      ex(8, {7'h00, 1'b1, r[7:0]});
      wr(CCR_ADDR_CFG, 8'h00);
      ex(4, r[15:0]);
      ex(6, 16'h0000);
      $display("test pointers done");
      // m bit 0 picks wide mode, bit 1 picks divide
      for (int m = 0; m < 4; m++) begin
         r = lfsr(r);
         a = r[7:0];
         b = r[15:8] | 8'h01;
         e = r[23:16];
         wr(CCR_ADDR_CFG, {4'h0, m[1] & m[0], ~m[1] & m[0], 2'b00});
         wr(CCR_ADDR_ACC, a);
         wr(CCR_ADDR_B, b);
         wr(CCR_ADDR_EXTENSION_BYTE_REG, e);
         wd = m[0] ? {e, a} : {8'h00, a};
         q16 = wd / b;
         rm = 8'(wd % b);
         res = m[1] ? {q16[15:8], rm, q16[7:0]} : 24'(wd) * 24'(b);
         op(m[1] ? CCR_OP_DIV : CCR_OP_MUL, 1'b0, 1'b0, 1'b0);
         ex(1, {8'h00, res[7:0]});
         rd(CCR_ADDR_B, res[15:8]);
         if (m[0]) rd(CCR_ADDR_EXTENSION_BYTE_REG, res[23:16]);
      end
      wr(CCR_ADDR_B, 8'h00);
      op(CCR_OP_DIV, 1'b0, 1'b0, 1'b0);
      ex(9, 16'h0001);
      $display("test arithmetic done");
      for (int i = 0; i < 4; i++) begin
         r = lfsr(r);
         wr(CCR_ADDR_ACC, r[7:0]);
         wr(CCR_ADDR_PSW, {r[15:13], i[1:0], r[10:8]});
         ex(5, {11'h000, i[1:0], 3'b000});
         op(CCR_OP_FLAGS, r[16], r[17], r[18]);
         ex(2, {8'h00, r[16], r[17], r[13], i[1:0], r[18], r[9],
            ^r[7:0]});
         rd(CCR_ADDR_PSW, {r[16], r[17], r[13], i[1:0], r[18], r[9],
            ^r[7:0]});
      end
      for (int i = 0; i < 4; i++) begin
         tick(1'b0, 1'b0, 1'b1);
         mreq_in.indirect <= i[0];
         mreq_in.addr <= {i[1], 7'h35};
         ex(7, {5'h00, i[1] & ~i[0], i[1] & i[0], ~i[1], i[1], 7'h35});
      end
      $display("test flags and routing done");
      tick();
      tick();
      test_done;
   end
endmodule
